// File: hw/fsr_defs.vh
// Register map, field positions, reset values and timing for pin routing
`ifndef FSR_DEFS_VH
`define FSR_DEFS_VH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define FSR_ADDR_W         8
`define FSR_OFS_AUX_CTRL   8'h00
`define FSR_OFS_FS_CTRL    8'h04
`define FSR_OFS_GPIO       8'h08
`define FSR_OFS_STATUS     8'h0c
`define FSR_OFS_FREQ_ONE   8'h10
`define FSR_OFS_FREQ_TWO   8'h14
`define FSR_OFS_FREQ_THREE 8'h18

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define FSR_AUX_EN_LSB     0
`define FSR_DIFF4_FMT_LSB  5
`define FSR_DIFF5_FMT_LSB  7
`define FSR_FS_SRC_LSB     0
`define FSR_FS_QUAL_LSB    4
`define FSR_FR_INV_BIT     6
`define FSR_FR_PUL_BIT     7
`define FSR_MF_INV_BIT     8
`define FSR_MF_PUL_BIT     9
`define FSR_GPIO_DIR_LSB   0
`define FSR_GPIO_OUT_LSB   4
`define FSR_GPIO_IN_LSB    8
`define FSR_ST_REF_LSB     0
`define FSR_ST_SYNC_BIT    4
`define FSR_ST_SYNC_OK_BIT 5
`define FSR_ST_EN_LSB      8

// ---------------------------------------------------------------
// Encodings and reset values
// ---------------------------------------------------------------
`define FSR_SRC_PIN_MAP    2'h3
`define FSR_QUAL_FOLLOW    2'h0
`define FSR_QUAL_PIN_A     2'h1
`define FSR_QUAL_PIN_B     2'h2
`define FSR_REF_TWO        4'h2
`define FSR_REF_THREE      4'h3
`define FSR_REF_FOUR       4'h4
`define FSR_REF_FIVE       4'h5
`define FSR_REF_SIX        4'h6
`define FSR_REF_NINE       4'h9
`define FSR_RST_FREQ_ONE   32'h017d7840
`define FSR_RST_FREQ_TWO   32'h03b9aca0
`define FSR_RST_FREQ_THREE 32'h04a28600

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define FSR_CLK_PERIOD_NS  100
`define FSR_FRAME_NS       125000
`define FSR_FRAME_CYCLES   (`FSR_FRAME_NS / `FSR_CLK_PERIOD_NS)
`define FSR_FRAMES_PER_MF  4
`define FSR_CNT_W          11
`define FSR_MF_W           2

`endif

// File: hw/fsr_pin_routing.v
// Frame-sync input routing and output clock pin mux with Avalon-MM registers
`timescale 1ns/1ps
`default_nettype none
`include "fsr_defs.vh"

// What this block does
// - Non-pin-map source: pin A only, B/C ignored
// - Pin map: pin A serves input three/five
// - Pin map: pin B serves input four/six
// - Pin map: pin C serves input nine/two
// - Sync inputs accept 2, 4, 8 kHz
// - Aux pins one-three: clock or GPIO
// - Aux pins four-five off unless enabled
// - Diff pairs mirror clocks four/five, format field
// - Frame output default 50% clock
// - Frame output invert and pulse controls
// - Multiframe output invert and pulse controls
// - Output clock frequencies reset to defaults
module fsr_pin_routing (
  input  wire        mclk,              // 10 MHz system clock
  input  wire        reset,             // Synchronous, active high
  input  wire [7:0]  avs_address,       // Byte address
  input  wire        avs_read,          // Read request
  input  wire        avs_write,         // Write request
  input  wire [31:0] avs_writedata,     // Write data
  input  wire [3:0]  avs_byteenable,    // Byte lanes
  output reg  [31:0] avs_readdata,      // Read data
  output reg         avs_waitrequest,   // Stall
  input  wire [4:0]  primary_clk,       // Primary output clocks one-five
  input  wire [3:0]  selected_ref,      // Currently selected input number
  input  wire        frame_sync_in_a,   // Sync pin A
  input  wire        frame_sync_in_b,   // Sync pin B
  input  wire        frame_sync_in_c,   // Sync pin C
  output reg         ext_frame_sync,    // Routed external frame sync
  output reg         ext_sync_valid,    // A sync pin is routed
  input  wire [2:0]  aux_gpio_in,       // Aux pins one-three input
  output reg  [2:0]  aux_gpio_out,      // Aux pins one-three output
  output reg  [2:0]  aux_gpio_oe,       // Aux pins one-three enable
  output reg         aux_four_out,      // Aux pin four output
  output reg         aux_four_oe,       // Aux pin four enable
  output reg         aux_five_out,      // Aux pin five output
  output reg         aux_five_oe,       // Aux pin five enable
  output reg         diff_four_p,       // Diff pair four, true
  output reg         diff_four_n,       // Diff pair four, complement
  output reg  [1:0]  diff_four_format,  // Pair four signalling mode
  output reg         diff_five_p,       // Diff pair five, true
  output reg         diff_five_n,       // Diff pair five, complement
  output reg  [1:0]  diff_five_format,  // Pair five signalling mode
  output reg         frame_pulse_out,   // 8 kHz frame output
  output reg         multiframe_pulse_out, // 2 kHz multiframe output
  output reg  [31:0] out_freq_one,      // Output clock one rate, Hz
  output reg  [31:0] out_freq_two,      // Output clock two rate, Hz
  output reg  [31:0] out_freq_three     // Output clock three rate, Hz
);

  // -------------------------------------------------------------
  // Control registers
  // -------------------------------------------------------------
  reg [4:0]  aux_enable;
  reg [3:0]  fs_source_select;
  reg [1:0]  fs_ref_qualifier;
  reg        frame_out_invert;
  reg        frame_out_pulse_mode;
  reg        multiframe_out_invert;
  reg        multiframe_out_pulse_mode;
  reg [2:0]  gpio_dir;
  reg [2:0]  gpio_val;
  reg [4:0]  eff_enable;
  reg [`FSR_CNT_W-1:0] frame_cnt;
  reg [`FSR_MF_W-1:0]  mf_cnt;

  wire       bus_req = avs_read | avs_write;
  wire       wr_go   = avs_write & ~avs_waitrequest;

  // -------------------------------------------------------------
  // Byte-lane merge
  // -------------------------------------------------------------
  function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0]  be;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (be[k])
          merge[k*8 +: 8] = wd[k*8 +: 8];
      end
    end
  endfunction

  // -------------------------------------------------------------
  // Register images for read and write
  // -------------------------------------------------------------
  reg [31:0] aux_img;
  reg [31:0] fs_img;
  reg [31:0] gpio_img;
  reg [31:0] stat_img;
  reg [31:0] rd_mux;

  always @* begin
    aux_img = 32'h0000_0000;
    aux_img[`FSR_AUX_EN_LSB +: 5] = aux_enable;
    aux_img[`FSR_DIFF4_FMT_LSB +: 2] = diff_four_format;
    aux_img[`FSR_DIFF5_FMT_LSB +: 2] = diff_five_format;
    fs_img = 32'h0000_0000;
    fs_img[`FSR_FS_SRC_LSB +: 4] = fs_source_select;
    fs_img[`FSR_FS_QUAL_LSB +: 2] = fs_ref_qualifier;
    fs_img[`FSR_FR_INV_BIT] = frame_out_invert;
    fs_img[`FSR_FR_PUL_BIT] = frame_out_pulse_mode;
    fs_img[`FSR_MF_INV_BIT] = multiframe_out_invert;
    fs_img[`FSR_MF_PUL_BIT] = multiframe_out_pulse_mode;
    gpio_img = 32'h0000_0000;
    gpio_img[`FSR_GPIO_DIR_LSB +: 3] = gpio_dir;
    gpio_img[`FSR_GPIO_OUT_LSB +: 3] = gpio_val;
    gpio_img[`FSR_GPIO_IN_LSB +: 3] = aux_gpio_in;
    stat_img = 32'h0000_0000;
    stat_img[`FSR_ST_REF_LSB +: 4] = selected_ref;
    stat_img[`FSR_ST_SYNC_BIT] = ext_frame_sync;
    stat_img[`FSR_ST_SYNC_OK_BIT] = ext_sync_valid;
    stat_img[`FSR_ST_EN_LSB +: 5] = eff_enable;
    case (avs_address)
      `FSR_OFS_AUX_CTRL:   rd_mux = aux_img;
      `FSR_OFS_FS_CTRL:    rd_mux = fs_img;
      `FSR_OFS_GPIO:       rd_mux = gpio_img;
      `FSR_OFS_STATUS:     rd_mux = stat_img;
      `FSR_OFS_FREQ_ONE:   rd_mux = out_freq_one;
      `FSR_OFS_FREQ_TWO:   rd_mux = out_freq_two;
      `FSR_OFS_FREQ_THREE: rd_mux = out_freq_three;
      default:             rd_mux = 32'h0000_0000;
    endcase
  end

  // -------------------------------------------------------------
  // Avalon slave: one wait cycle, then a one-cycle release
  // -------------------------------------------------------------
  reg [31:0] wr_aux;
  reg [31:0] wr_fs;
  reg [31:0] wr_gpio;

  always @* begin
    wr_aux  = merge(aux_img, avs_writedata, avs_byteenable);
    wr_fs   = merge(fs_img, avs_writedata, avs_byteenable);
    wr_gpio = merge(gpio_img, avs_writedata, avs_byteenable);
  end

  always @(posedge mclk) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      if (bus_req & avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata <= avs_read ? rd_mux : 32'h0000_0000;
      end else begin
        avs_waitrequest <= 1'b1;
      end
    end
  end

  always @(posedge mclk) begin
    if (reset) begin
      aux_enable <= 5'h00;
      diff_four_format <= 2'h0;
      diff_five_format <= 2'h0;
      fs_source_select <= 4'h0;
      fs_ref_qualifier <= 2'h0;
      frame_out_invert <= 1'b0;
      frame_out_pulse_mode <= 1'b0;
      multiframe_out_invert <= 1'b0;
      multiframe_out_pulse_mode <= 1'b0;
      gpio_dir <= 3'h0;
      gpio_val <= 3'h0;
      out_freq_one <= `FSR_RST_FREQ_ONE;
      out_freq_two <= `FSR_RST_FREQ_TWO;
      out_freq_three <= `FSR_RST_FREQ_THREE;
    end else if (wr_go) begin
      case (avs_address)
        `FSR_OFS_AUX_CTRL: begin
          aux_enable <= wr_aux[`FSR_AUX_EN_LSB +: 5];
          diff_four_format <= wr_aux[`FSR_DIFF4_FMT_LSB +: 2];
          diff_five_format <= wr_aux[`FSR_DIFF5_FMT_LSB +: 2];
        end
        `FSR_OFS_FS_CTRL: begin
          fs_source_select <= wr_fs[`FSR_FS_SRC_LSB +: 4];
          fs_ref_qualifier <= wr_fs[`FSR_FS_QUAL_LSB +: 2];
          frame_out_invert <= wr_fs[`FSR_FR_INV_BIT];
          frame_out_pulse_mode <= wr_fs[`FSR_FR_PUL_BIT];
          multiframe_out_invert <= wr_fs[`FSR_MF_INV_BIT];
          multiframe_out_pulse_mode <= wr_fs[`FSR_MF_PUL_BIT];
        end
        `FSR_OFS_GPIO: begin
          gpio_dir <= wr_gpio[`FSR_GPIO_DIR_LSB +: 3];
          gpio_val <= wr_gpio[`FSR_GPIO_OUT_LSB +: 3];
        end
        `FSR_OFS_FREQ_ONE:
          out_freq_one <= merge(out_freq_one, avs_writedata, avs_byteenable);
        `FSR_OFS_FREQ_TWO:
          out_freq_two <= merge(out_freq_two, avs_writedata, avs_byteenable);
        `FSR_OFS_FREQ_THREE:
          out_freq_three <= merge(out_freq_three, avs_writedata,
                                  avs_byteenable);
        default: begin
          aux_enable <= aux_enable;
        end
      endcase
    end
  end

  // -------------------------------------------------------------
  // Frame-sync input routing
  // -------------------------------------------------------------
  // Rate is not checked: a sync edge of any supported rate passes.
  reg next_sync;
  reg next_valid;

  always @* begin
    next_sync  = 1'b0;
    next_valid = 1'b0;
    if (fs_source_select[3:2] != `FSR_SRC_PIN_MAP) begin
      next_sync  = frame_sync_in_a;
      next_valid = 1'b1;
    end else begin
      case (fs_ref_qualifier)
        `FSR_QUAL_PIN_A: begin
          next_sync  = frame_sync_in_a;
          next_valid = 1'b1;
        end
        `FSR_QUAL_PIN_B: begin
          next_sync  = frame_sync_in_b;
          next_valid = 1'b1;
        end
        `FSR_QUAL_FOLLOW: begin
          case (selected_ref)
            `FSR_REF_THREE, `FSR_REF_FIVE: begin
              next_sync  = frame_sync_in_a;
              next_valid = 1'b1;
            end
            `FSR_REF_FOUR, `FSR_REF_SIX: begin
              next_sync  = frame_sync_in_b;
              next_valid = 1'b1;
            end
            `FSR_REF_NINE, `FSR_REF_TWO: begin
              next_sync  = frame_sync_in_c;
              next_valid = 1'b1;
            end
            default: begin
              next_sync  = 1'b0;
              next_valid = 1'b0;
            end
          endcase
        end
        default: begin
          next_sync  = frame_sync_in_c;
          next_valid = 1'b1;
        end
      endcase
    end
  end

  always @(posedge mclk) begin
    if (reset) begin
      ext_frame_sync <= 1'b0;
      ext_sync_valid <= 1'b0;
    end else begin
      ext_frame_sync <= next_sync;
      ext_sync_valid <= next_valid;
    end
  end

  // -------------------------------------------------------------
  // Output clock pins
  // -------------------------------------------------------------
  // An enable change lands only while its clock is low, so an
  // enabled pin never sees a runt high phase.
  reg [4:0] next_eff;
  integer i;
  integer j;

  always @* begin
    next_eff = eff_enable;
    for (i = 0; i < 5; i = i + 1) begin
      if (!primary_clk[i])
        next_eff[i] = aux_enable[i];
    end
  end

  always @(posedge mclk) begin
    if (reset) begin
      eff_enable <= 5'h00;
      aux_gpio_out <= 3'h0;
      aux_gpio_oe <= 3'h0;
      aux_four_out <= 1'b0;
      aux_four_oe <= 1'b0;
      aux_five_out <= 1'b0;
      aux_five_oe <= 1'b0;
      diff_four_p <= 1'b0;
      diff_four_n <= 1'b1;
      diff_five_p <= 1'b0;
      diff_five_n <= 1'b1;
    end else begin
      eff_enable <= next_eff;
      for (j = 0; j < 3; j = j + 1) begin
        if (next_eff[j]) begin
          aux_gpio_out[j] <= primary_clk[j];
          aux_gpio_oe[j] <= 1'b1;
        end else begin
          aux_gpio_out[j] <= gpio_val[j];
          aux_gpio_oe[j] <= gpio_dir[j];
        end
      end
      aux_four_out <= primary_clk[3] & next_eff[3];
      aux_four_oe <= next_eff[3];
      aux_five_out <= primary_clk[4] & next_eff[4];
      aux_five_oe <= next_eff[4];
      diff_four_p <= primary_clk[3];
      diff_four_n <= ~primary_clk[3];
      diff_five_p <= primary_clk[4];
      diff_five_n <= ~primary_clk[4];
    end
  end

  // -------------------------------------------------------------
  // Frame and multiframe outputs
  // -------------------------------------------------------------
  // Multiframe shares the frame counter so both stay phase aligned.
  localparam integer FRAME_LAST_I = `FSR_FRAME_CYCLES - 1;
  localparam integer FRAME_HALF_I = `FSR_FRAME_CYCLES / 2;
  localparam integer MF_HALF_I    = `FSR_FRAMES_PER_MF / 2;
  localparam [`FSR_CNT_W-1:0] FRAME_LAST = FRAME_LAST_I[`FSR_CNT_W-1:0];
  localparam [`FSR_CNT_W-1:0] FRAME_HALF = FRAME_HALF_I[`FSR_CNT_W-1:0];
  localparam [`FSR_MF_W-1:0]  MF_HALF    = MF_HALF_I[`FSR_MF_W-1:0];

  wire frame_wrap = (frame_cnt == FRAME_LAST);
  wire fr_level = frame_out_pulse_mode ? (frame_cnt == {`FSR_CNT_W{1'b0}})
                                       : (frame_cnt < FRAME_HALF);
  wire mf_level = multiframe_out_pulse_mode ?
                  ((frame_cnt == {`FSR_CNT_W{1'b0}}) &&
                   (mf_cnt == {`FSR_MF_W{1'b0}}))
                  : (mf_cnt < MF_HALF);

  always @(posedge mclk) begin
    if (reset) begin
      frame_cnt <= {`FSR_CNT_W{1'b0}};
      mf_cnt <= {`FSR_MF_W{1'b0}};
      frame_pulse_out <= 1'b0;
      multiframe_pulse_out <= 1'b0;
    end else begin
      frame_cnt <= frame_wrap ? {`FSR_CNT_W{1'b0}}
                              : frame_cnt + 1'b1;
      if (frame_wrap)
        mf_cnt <= mf_cnt + 1'b1;
      frame_pulse_out <= fr_level ^ frame_out_invert;
      multiframe_pulse_out <= mf_level ^ multiframe_out_invert;
    end
  end

endmodule
`default_nettype wire

// File: test/fsr_far_side.sv
// Far-side model: sync sources, primary clocks and aux pin drivers
`timescale 1ns/1ps
`default_nettype none
module fsr_far_side #(
  parameter integer SYNC_HALF = 3   // Shortened fastest half period
) (
  input  wire logic       mclk,        // Clock
  input  wire logic       reset,       // Sync reset
  output var  logic [4:0] primary_clk, // Primary clocks
  output var  logic       sync_a,      // Fast rate source
  output var  logic       sync_b,      // Half rate source
  output var  logic       sync_c,      // Quarter rate source
  output var  logic [2:0] gpio_drive   // Level on undriven aux pins
);
  integer n;
  assign gpio_drive = 3'h5;
  always @(posedge mclk) begin
    if (reset) begin
      n <= 0;
      primary_clk <= 5'h0;
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
    end else begin
      n <= n + 1;
      for (int k = 0; k < 5; k++)
        if (n % (k + 1) == 0) primary_clk[k] <= ~primary_clk[k];
      // Three rates in a 1:2:4 ratio, as the sync pins may carry
      sync_a <= (n % (2 * SYNC_HALF)) < SYNC_HALF;
      sync_b <= (n % (4 * SYNC_HALF)) < 2 * SYNC_HALF;
      sync_c <= (n % (8 * SYNC_HALF)) < 4 * SYNC_HALF;
    end
  end
endmodule
`default_nettype wire

// File: test/fsr_pin_routing_asserts.sv
// Port-level assertions for the pin routing block
`timescale 1ns/1ps
`default_nettype none
`include "fsr_defs.vh"
module fsr_pin_routing_asserts (
  input wire logic        mclk,           // Clock
  input wire logic        reset,          // Sync reset
  input wire logic        avs_write,      // Bus write
  input wire logic [4:0]  primary_clk,    // Primary clocks
  input wire logic        ext_frame_sync, // Routed sync
  input wire logic        ext_sync_valid, // Routing valid
  input wire logic        aux_four_out,   // Aux four
  input wire logic        aux_four_oe,    // Aux four enable
  input wire logic        aux_five_out,   // Aux five
  input wire logic        aux_five_oe,    // Aux five enable
  input wire logic        diff_four_p,    // Pair four true
  input wire logic        diff_four_n,    // Pair four comp
  input wire logic        diff_five_p,    // Pair five true
  input wire logic        diff_five_n,    // Pair five comp
  input wire logic [31:0] out_freq_one    // Rate one
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  rst_value_a: assert property ($past(reset) |-> !aux_four_oe &&
    !aux_five_oe && out_freq_one == `FSR_RST_FREQ_ONE)
    else $error("reset values wrong");
  aux_four_a: assert property (aux_four_oe |->
    aux_four_out == $past(primary_clk[3])) else $error("aux four copy");
  aux_five_a: assert property (aux_five_oe |->
    aux_five_out == $past(primary_clk[4])) else $error("aux five copy");
  // An enable may only open while the clock is low, else a runt pulse
  aux_clean_a: assert property (!($rose(aux_four_oe) && aux_four_out) &&
    !($rose(aux_five_oe) && aux_five_out)) else $error("enable glitch");
  diff_four_a: assert property (!$past(reset) |->
    diff_four_p == $past(primary_clk[3]) && diff_four_n == !diff_four_p)
    else $error("pair four copy");
  diff_five_a: assert property (!$past(reset) |->
    diff_five_p == $past(primary_clk[4]) && diff_five_n == !diff_five_p)
    else $error("pair five copy");
  sync_gate_a: assert property (!ext_sync_valid |-> !ext_frame_sync)
    else $error("sync without route");
  freq_hold_a: assert property (!$past(reset) && !$past(avs_write) |->
    $stable(out_freq_one)) else $error("rate moved unwritten");
endmodule

bind fsr_pin_routing fsr_pin_routing_asserts u_chk (.mclk(mclk),
  .reset(reset), .avs_write(avs_write), .primary_clk(primary_clk),
  .ext_frame_sync(ext_frame_sync), .ext_sync_valid(ext_sync_valid),
  .aux_four_out(aux_four_out), .aux_four_oe(aux_four_oe),
  .aux_five_out(aux_five_out), .aux_five_oe(aux_five_oe),
  .diff_four_p(diff_four_p), .diff_four_n(diff_four_n),
  .diff_five_p(diff_five_p), .diff_five_n(diff_five_n),
  .out_freq_one(out_freq_one));
`default_nettype wire

// File: test/testbench.sv
// Self-checking bench for the pin routing block
`timescale 1ns/1ps
`default_nettype none
`include "fsr_defs.vh"
module testbench;
  logic mclk, reset, avs_read, avs_write, avs_waitrequest;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [4:0] primary_clk;
  logic [3:0] selected_ref;
  logic frame_sync_in_a, frame_sync_in_b, frame_sync_in_c;
  logic ext_frame_sync, ext_sync_valid, aux_four_out, aux_four_oe;
  logic aux_five_out, aux_five_oe, diff_four_p, diff_four_n;
  logic diff_five_p, diff_five_n, frame_pulse_out, multiframe_pulse_out;
  logic [2:0] aux_gpio_in, aux_gpio_out, aux_gpio_oe, gpio_drive;
  logic [1:0] diff_four_format, diff_five_format;
  logic [31:0] out_freq_one, out_freq_two, out_freq_three;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;

  // Pin level: whoever enables wins, otherwise the outside driver
  assign aux_gpio_in = (aux_gpio_oe & aux_gpio_out) |
                       (~aux_gpio_oe & gpio_drive);

  fsr_pin_routing u_dut (.mclk(mclk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .primary_clk(primary_clk), .selected_ref(selected_ref),
    .frame_sync_in_a(frame_sync_in_a), .frame_sync_in_b(frame_sync_in_b),
    .frame_sync_in_c(frame_sync_in_c), .ext_frame_sync(ext_frame_sync),
    .ext_sync_valid(ext_sync_valid), .aux_gpio_in(aux_gpio_in),
    .aux_gpio_out(aux_gpio_out), .aux_gpio_oe(aux_gpio_oe),
    .aux_four_out(aux_four_out), .aux_four_oe(aux_four_oe),
    .aux_five_out(aux_five_out), .aux_five_oe(aux_five_oe),
    .diff_four_p(diff_four_p), .diff_four_n(diff_four_n),
    .diff_four_format(diff_four_format), .diff_five_p(diff_five_p),
    .diff_five_n(diff_five_n), .diff_five_format(diff_five_format),
    .frame_pulse_out(frame_pulse_out),
    .multiframe_pulse_out(multiframe_pulse_out),
    .out_freq_one(out_freq_one), .out_freq_two(out_freq_two),
    .out_freq_three(out_freq_three));

  fsr_far_side #(.SYNC_HALF(3)) u_far (.mclk(mclk), .reset(reset),
    .primary_clk(primary_clk), .sync_a(frame_sync_in_a),
    .sync_b(frame_sync_in_b), .sync_c(frame_sync_in_c),
    .gpio_drive(gpio_drive));

  always #50 mclk = ~mclk;

  task close_out;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      bad_count++;
      close_out;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, s, got, exp);
    end
  endtask

  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] q);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  function automatic logic pick(input int e);
    pick = (e == 0) ? frame_sync_in_a : (e == 1) ? frame_sync_in_b :
           (e == 2) ? frame_sync_in_c : 1'b0;
  endfunction

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task t_reset;
    logic [31:0] q;
    logic [31:0] rf [3];
    rf = '{`FSR_RST_FREQ_ONE, `FSR_RST_FREQ_TWO, `FSR_RST_FREQ_THREE};
    @(negedge mclk);
    chk({aux_gpio_oe, aux_four_oe, aux_five_oe}, 0, "enables off");
    chk(out_freq_three, `FSR_RST_FREQ_THREE, "rate port");
    for (int i = 0; i < 3; i++) begin
      bus(0, `FSR_OFS_FREQ_ONE + 8'(4 * i), 0, q);
      chk(q, rf[i], "rate reset");
    end
    bus(1, `FSR_OFS_FREQ_TWO, 32'h00bebc20, q);
    bus(0, `FSR_OFS_FREQ_TWO, 0, q);
    chk(q, 32'h00bebc20, "rate write");
    chk(out_freq_two, 32'h00bebc20, "rate port");
    bus(0, 8'h20, 0, q);
    chk(q, 0, "unmapped");
    bus(1, `FSR_OFS_STATUS, 32'hffffffff, q);
    bus(0, `FSR_OFS_STATUS, 0, q);
    chk(q[3:0], 4'h3, "status ro");
  endtask

  task t_route;
    logic [15:0] tbl [12];
    logic [31:0] q;
    logic p;
    int e;
    // {source, qualifier, selected input, expected pin or 3 for none}
    tbl = '{16'h0030, 16'h5040, 16'hc030, 16'hc050, 16'hc041, 16'hc061,
            16'hc092, 16'hc022, 16'hc073, 16'hf190, 16'hf291, 16'hf392};
    foreach (tbl[i]) begin
      bus(1, `FSR_OFS_FS_CTRL, {26'h0, tbl[i][9:8], tbl[i][15:12]}, q);
      selected_ref <= tbl[i][7:4];
      e = tbl[i][3:0];
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      p = pick(e);
      repeat (24) begin
        @(negedge mclk);
        chk(ext_frame_sync, p, "routed sync");
        chk(ext_sync_valid, e != 3, "sync valid");
        p = pick(e);
      end
    end
  endtask

  task t_aux;
    logic [31:0] q;
    logic [4:0] pc;
    logic [3:0] dx;
    bus(1, `FSR_OFS_GPIO, 32'h00000063, q);
    repeat (3) @(posedge mclk);
    bus(0, `FSR_OFS_GPIO, 0, q);
    chk(q[10:8], 3'h6, "gpio pin level");
    @(negedge mclk);
    chk({aux_gpio_oe, aux_gpio_out}, 6'h1e, "gpio drive");
    bus(1, `FSR_OFS_AUX_CTRL, 32'h000000df, q);
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    pc = primary_clk;
    repeat (20) begin
      @(negedge mclk);
      dx = {pc[3], ~pc[3], pc[4], ~pc[4]};
      chk({aux_gpio_oe, aux_four_oe, aux_five_oe}, 5'h1f, "oe");
      chk({aux_five_out, aux_four_out, aux_gpio_out}, pc, "copy");
      chk({diff_four_p, diff_four_n, diff_five_p, diff_five_n},
          dx, "diff");
      chk({diff_four_format, diff_five_format}, 4'h9, "format");
      pc = primary_clk;
    end
    bus(1, `FSR_OFS_AUX_CTRL, 0, q);
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    chk({aux_gpio_oe, aux_four_oe, aux_five_oe}, 5'h0c, "back off");
  endtask

  task t_frame(input logic [31:0] ctl, input int ef, input int em);
    logic [31:0] q, f, m;
    bus(1, `FSR_OFS_FS_CTRL, ctl, q);
    repeat (2) @(posedge mclk);
    f = 0;
    m = 0;
    // One whole multiframe, so the totals do not depend on phase
    repeat (5000) begin
      @(negedge mclk);
      f = f + frame_pulse_out;
      m = m + multiframe_pulse_out;
    end
    chk(f, ef, "frame high");
    chk(m, em, "multiframe high");
  endtask

  initial begin
    mclk = 1'b0;
    reset = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    selected_ref = 4'h3;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    t_reset;
    t_route;
    t_aux;
    t_frame(32'h0, 2500, 2500);
    t_frame(32'h280, 4, 1);
    t_frame(32'h3c0, 4996, 4999);
    close_out;
  end
endmodule
`default_nettype wire
